// ### tm2_cfg.svh
`ifndef TM2_CFG_SVH
`define TM2_CFG_SVH

// register offsets on the plain register port
`define TM2_OFS_CTRL       3'h0
`define TM2_OFS_MODE       3'h1
`define TM2_OFS_CNT_LO     3'h2
`define TM2_OFS_CNT_HI     3'h3
`define TM2_OFS_RLD_LO     3'h4
`define TM2_OFS_RLD_HI     3'h5
`define TM2_OFS_IRQ_STS    3'h6
`define TM2_OFS_IRQ_MSK    3'h7

// timer_control_reg fields
`define TM2_CTL_OVF        7
`define TM2_CTL_EXT        6
`define TM2_CTL_RCLK       5
`define TM2_CTL_TRANSMIT_CLOCK_SELECT       4
`define TM2_CTL_EXEN       3
`define TM2_CTL_RUN        2
`define TM2_CTL_CT         1
`define TM2_CTL_CPRL       0

// timer_mode_reg fields
`define TM2_MOD_OE         1
`define TM2_MOD_DOWN_COUNT_ENABLE       0

// interrupt status / mask fields
`define TM2_IRQ_OVF        0
`define TM2_IRQ_EXT        1

// reset values and count top
`define TM2_RST_BYTE       8'h00
`define TM2_RST_WORD       16'h0000
`define TM2_CNT_TOP        16'hFFFF

// timing: internal count divider and clock-out rate divider
`define TM2_PRESC_DIV      12
`define TM2_FAST_DIV       2

`endif

// ### tm2_pkg.sv
package tm2_pkg;

    typedef logic [7:0]  tm2_byte_t;
    typedef logic [15:0] tm2_word_t;

    // operating mode selected from the serial clock selects, capture/reload select, down-count enable and output enable
    typedef enum logic [1:0] {
        TM2_MD_CAPTURE = 2'h0,
        TM2_MD_RELOAD  = 2'h1,
        TM2_MD_UPDOWN  = 2'h3,
        TM2_MD_BAUD    = 2'h2
    } tm2_mode_e;

endpackage

// ### tm2_pin_if.sv
`timescale 1ns/1ps
interface tm2_pin_if;
    logic [1:0] lvl;   // [0] count pin, [1] direction pin
    logic [1:0] fall;  // one-cycle falling edge pulses

    modport edge_mp (input lvl, output fall);
    modport core_mp (input lvl, input fall);
endinterface

// ### tm2_edge.sv
`timescale 1ns/1ps
module tm2_edge #(
    parameter int NPIN = 2
) (
    // clock and reset
    input  wire logic core_clk_i,
    input  wire logic rst_n_i,
    // pin levels in, fall pulses out
    tm2_pin_if.edge_mp pins
);
    generate
        if (NPIN != 2) begin : g_chk
            $error("tm2_edge serves exactly two pins");
        end
    endgenerate

    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++) begin : g_pin
            logic prev_q;
            // pins are synchronous; one flop of history is enough for edge detection
            always_ff @(posedge core_clk_i) begin
                if (!rst_n_i) begin
                    prev_q <= 1'b1;
                end else begin
                    prev_q <= pins.lvl[gi];
                end
            end
            assign pins.fall[gi] = prev_q & ~pins.lvl[gi];
        end
    endgenerate
endmodule // tm2_edge

// ### tm2_top.sv
`timescale 1ns/1ps
`include "tm2_cfg.svh"

// Overview of operation
// - count is sixteen bits: low byte carries into high byte
// - counter/timer select picks internal divide-by-twelve or count pin falling edges
// - count advances only while run control is set
// - serial clock selects and capture/reload select choose capture, reload or baud mode
// - reload mode with down-count enable and output enable clear counts up or down per direction pin
// - counting up wraps after FFFF: overflow flag, interrupt, load reload pair, or roll to 0000 in capture mode
// - counting down reaching reload pair: overflow flag, load FFFF
// - up/down mode toggles external flag on each wrap, without interrupt
// - clock-out mode counts at half clock rate, output square wave 50 percent
// - clock-out mode reloads on overflow and raises no interrupt
// - generated clock on count pin at clock over four times (65536 minus reload)
// - baud generation and clock-out run together on the shared reload pair
// - any serial clock select forces auto-reload, ignoring capture/reload select
// - external enable outside baud and up/down modes: direction pin fall captures or reloads
// - output enable turns count pin into a clock output, else an input
module tm2_top #(
    parameter int PRESC_DIV = `TM2_PRESC_DIV
) (
    // clock and reset
    input  wire logic            core_clk_i,
    input  wire logic            rst_n_i,
    // register port
    input  wire logic [2:0]      reg_addr_i,
    input  wire tm2_pkg::tm2_byte_t reg_wdata_i,
    input  wire logic            reg_wr_i,
    input  wire logic            reg_rd_i,
    output tm2_pkg::tm2_byte_t   reg_rdata_o,
    // pins
    input  wire logic            count_pin_i,
    output logic                 count_pin_o,
    output logic                 count_pin_oe_o,
    input  wire logic            dir_pin_i,
    // system
    output logic                 irq_o,
    output logic                 baud_tick_o
);
    import tm2_pkg::*;

    generate
        if (PRESC_DIV < 2 || PRESC_DIV > 255) begin : g_chk
            $error("PRESC_DIV must lie in 2..255");
        end
    endgenerate

    tm2_byte_t  ctrl_q, mode_q, msk_q, sts_q, rdata_q;
    tm2_word_t  cnt_q, rld_q;
    logic [7:0] presc_q;
    logic       half_q, clkout_q, baud_tick_q;
    tm2_mode_e  md;

    tm2_pin_if pins ();
    assign pins.lvl = {dir_pin_i, count_pin_i};

    tm2_edge #(.NPIN(2)) u_edge (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .pins       (pins)
    );

    // decode of register writes
    logic wr_ctrl, wr_mode, wr_clo, wr_chi, wr_rlo, wr_rhi, wr_msk, rd_sts;
    always_comb begin
        wr_ctrl = 1'b0;
        wr_mode = 1'b0;
        wr_clo  = 1'b0;
        wr_chi  = 1'b0;
        wr_rlo  = 1'b0;
        wr_rhi  = 1'b0;
        wr_msk  = 1'b0;
        if (reg_addr_i == `TM2_OFS_CTRL) begin
            wr_ctrl = reg_wr_i;
        end else if (reg_addr_i == `TM2_OFS_MODE) begin
            wr_mode = reg_wr_i;
        end else if (reg_addr_i == `TM2_OFS_CNT_LO) begin
            wr_clo = reg_wr_i;
        end else if (reg_addr_i == `TM2_OFS_CNT_HI) begin
            wr_chi = reg_wr_i;
        end else if (reg_addr_i == `TM2_OFS_RLD_LO) begin
            wr_rlo = reg_wr_i;
        end else if (reg_addr_i == `TM2_OFS_RLD_HI) begin
            wr_rhi = reg_wr_i;
        end else if (reg_addr_i == `TM2_OFS_IRQ_MSK) begin
            wr_msk = reg_wr_i;
        end
    end
    assign rd_sts = reg_rd_i && (reg_addr_i == `TM2_OFS_IRQ_STS);

    // mode and field aliases
    logic run, ct, exen, baud, oe, down_count_enable, fast, updown, capture;
    assign run  = ctrl_q[`TM2_CTL_RUN];
    assign ct   = ctrl_q[`TM2_CTL_CT];
    assign exen = ctrl_q[`TM2_CTL_EXEN];
    assign oe   = mode_q[`TM2_MOD_OE];
    assign down_count_enable = mode_q[`TM2_MOD_DOWN_COUNT_ENABLE];
    assign baud = ctrl_q[`TM2_CTL_RCLK] | ctrl_q[`TM2_CTL_TRANSMIT_CLOCK_SELECT];

    always_comb begin
        if (baud) begin
            md = TM2_MD_BAUD;
        end else if (ctrl_q[`TM2_CTL_CPRL]) begin
            md = TM2_MD_CAPTURE;
        end else if (down_count_enable && !oe) begin
            md = TM2_MD_UPDOWN;
        end else begin
            md = TM2_MD_RELOAD;
        end
    end
    assign updown  = (md == TM2_MD_UPDOWN);
    assign capture = (md == TM2_MD_CAPTURE);

    // count source: the half-rate tick serves clock-out and baud alike, so both share one counter
    assign fast = !ct && (oe || baud);
    logic presc_tick, src_tick, tick;
    assign presc_tick = (presc_q == 8'(PRESC_DIV - 1));

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            presc_q <= 8'h00;
            half_q  <= 1'b0;
        end else begin
            presc_q <= presc_tick ? 8'h00 : presc_q + 8'h01;
            half_q  <= ~half_q;
        end
    end

    // count pin edges are ignored while the pin is driven as clock output
    assign src_tick = ct ? (pins.fall[0] & ~oe) : (fast ? half_q : presc_tick);
    assign tick     = run & src_tick;

    logic up_dir, ovf_wrap, unf_wrap, wrap, ext_evt, set_ovf;
    assign up_dir   = !(updown && !dir_pin_i);
    assign ovf_wrap = tick && up_dir && (cnt_q == `TM2_CNT_TOP);
    assign unf_wrap = tick && !up_dir && (cnt_q == rld_q);
    assign wrap     = ovf_wrap | unf_wrap;
    assign ext_evt  = exen && pins.fall[1] && !baud && !updown;
    // no flag in baud or clock-out use; those overflows only feed their clocks
    assign set_ovf  = wrap && !baud && !oe;

    // counter: a software write beats any hardware load in the same cycle
    logic [8:0] lo_sum;
    assign lo_sum = {1'b0, cnt_q[7:0]} + 9'h001;
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            cnt_q <= `TM2_RST_WORD;
        end else if (wr_clo || wr_chi) begin
            if (wr_clo) cnt_q[7:0] <= reg_wdata_i;
            if (wr_chi) cnt_q[15:8] <= reg_wdata_i;
        end else if (ext_evt && !capture) begin
            cnt_q <= rld_q;
        end else if (unf_wrap) begin
            cnt_q <= `TM2_CNT_TOP;
        end else if (ovf_wrap && !capture) begin
            cnt_q <= rld_q;
        end else if (tick && up_dir) begin
            cnt_q <= {cnt_q[15:8] + 8'(lo_sum[8]), lo_sum[7:0]};
        end else if (tick) begin
            cnt_q <= cnt_q - 16'h0001;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            rld_q <= `TM2_RST_WORD;
        end else if (wr_rlo || wr_rhi) begin
            if (wr_rlo) rld_q[7:0] <= reg_wdata_i;
            if (wr_rhi) rld_q[15:8] <= reg_wdata_i;
        end else if (ext_evt && capture) begin
            rld_q <= cnt_q;
        end
    end

    // control: hardware flag sets win over a software clear in the same cycle
    tm2_byte_t ctrl_base;
    assign ctrl_base = wr_ctrl ? reg_wdata_i : ctrl_q;
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            ctrl_q <= `TM2_RST_BYTE;
        end else begin
            ctrl_q <= ctrl_base;
            ctrl_q[`TM2_CTL_OVF] <= ctrl_base[`TM2_CTL_OVF] | set_ovf;
            ctrl_q[`TM2_CTL_EXT] <= (ctrl_base[`TM2_CTL_EXT] ^ (updown & wrap)) | ext_evt;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            mode_q <= `TM2_RST_BYTE;
            msk_q  <= `TM2_RST_BYTE;
        end else begin
            if (wr_mode) mode_q <= {6'h00, reg_wdata_i[1:0]};
            if (wr_msk) msk_q <= {6'h00, reg_wdata_i[1:0]};
        end
    end

    // interrupt status: read clears, new events in the read cycle survive
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            sts_q <= `TM2_RST_BYTE;
        end else begin
            sts_q <= (rd_sts ? `TM2_RST_BYTE : sts_q)
                     | {6'h00, ext_evt, set_ovf};
        end
    end
    assign irq_o = |(sts_q & msk_q);

    // clock-out: toggle per overflow gives period of four times the reload span
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            clkout_q    <= 1'b0;
            baud_tick_q <= 1'b0;
        end else begin
            if (ovf_wrap && oe) clkout_q <= ~clkout_q;
            baud_tick_q <= ovf_wrap & baud;
        end
    end
    assign count_pin_o    = clkout_q;
    assign count_pin_oe_o = oe;
    assign baud_tick_o    = baud_tick_q;

    // read data, valid in the cycle after the strobe only
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i || !reg_rd_i) begin
            rdata_q <= `TM2_RST_BYTE;
        end else if (reg_addr_i == `TM2_OFS_CTRL) begin
            rdata_q <= ctrl_q;
        end else if (reg_addr_i == `TM2_OFS_MODE) begin
            rdata_q <= mode_q;
        end else if (reg_addr_i == `TM2_OFS_CNT_LO) begin
            rdata_q <= cnt_q[7:0];
        end else if (reg_addr_i == `TM2_OFS_CNT_HI) begin
            rdata_q <= cnt_q[15:8];
        end else if (reg_addr_i == `TM2_OFS_RLD_LO) begin
            rdata_q <= rld_q[7:0];
        end else if (reg_addr_i == `TM2_OFS_RLD_HI) begin
            rdata_q <= rld_q[15:8];
        end else if (reg_addr_i == `TM2_OFS_IRQ_STS) begin
            rdata_q <= sts_q;
        end else begin
            rdata_q <= msk_q;
        end
    end
    assign reg_rdata_o = rdata_q;

    logic sw_cnt;
    assign sw_cnt = wr_clo | wr_chi;

    default clocking dc @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    run_hold_a: assert property (!run && !sw_cnt && !ext_evt |=> $stable(cnt_q))
        else $error("count moved while stopped");
    up_reload_a: assert property (ovf_wrap && !capture && !sw_cnt && !ext_evt |=> cnt_q == $past(rld_q))
        else $error("overflow did not load reload pair");
    down_top_a: assert property (unf_wrap && !sw_cnt && !ext_evt |=> cnt_q == `TM2_CNT_TOP)
        else $error("underflow did not load top");
    ovf_flag_a: assert property (set_ovf |=> ctrl_q[`TM2_CTL_OVF] && sts_q[`TM2_IRQ_OVF])
        else $error("overflow flag not set");
    ext_toggle_a: assert property (updown && wrap && !wr_ctrl |=> ctrl_q[`TM2_CTL_EXT] != $past(ctrl_q[`TM2_CTL_EXT]))
        else $error("external flag did not toggle");
    clk_toggle_a: assert property (ovf_wrap && oe |=> count_pin_o != $past(count_pin_o))
        else $error("clock-out did not toggle");
    clkout_quiet_a: assert property (oe && !baud && !ct && ovf_wrap && !sts_q[`TM2_IRQ_OVF] && !rd_sts
                                     |=> !sts_q[`TM2_IRQ_OVF])
        else $error("clock-out overflow raised interrupt");
    flag_sticky_a: assert property (ctrl_q[`TM2_CTL_OVF] && !wr_ctrl |=> ctrl_q[`TM2_CTL_OVF])
        else $error("overflow flag cleared by hardware");
    irq_path_a: assert property (set_ovf && msk_q[`TM2_IRQ_OVF] && !wr_msk |=> irq_o)
        else $error("masked-in overflow gave no interrupt");
    half_rate_a: assert property (run && fast && tick && !wrap && !sw_cnt && !ext_evt |=> !tick ##1 1)
        else $error("clock-out counted faster than half rate");

    up_wrap_c: cover property (ovf_wrap && !oe && !baud);
    down_wrap_c: cover property (unf_wrap);
    clkout_c: cover property (ovf_wrap && oe);
    capture_c: cover property (ext_evt && capture);
endmodule // tm2_top

// ### tm2_pin_model.sv
`timescale 1ns/1ps
module tm2_pin_model (
    // clock
    input  wire logic  core_clk_i,
    // resolved count pin wire
    input  wire logic  pin_wire_i,
    // pins toward the timer
    output logic       cnt_drv_o,
    output logic       cnt_oe_o,
    output logic       dir_o,
    // last measured half period of the pin, in clocks
    output int unsigned half_per_o
);
    int unsigned run_q = 0;
    logic        last_q = 1'b1;

    initial begin
        cnt_drv_o = 1'b1;
        // released pin rests high on its pull-up
        cnt_oe_o = 1'b0;
        dir_o = 1'b1;
        half_per_o = 0;
    end

    // each pulse: two clocks low, three or more high, so the edge detector cannot miss it
    task automatic pulse(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge core_clk_i);
            cnt_oe_o  <= 1'b1;
            cnt_drv_o <= 1'b0;
            repeat (2) @(posedge core_clk_i);
            cnt_drv_o <= 1'b1;
            @(posedge core_clk_i);
            cnt_oe_o  <= 1'b0;
            @(posedge core_clk_i);
        end
        repeat (3) @(posedge core_clk_i);
    endtask

    task automatic set_dir(input logic v);
        @(posedge core_clk_i);
        dir_o <= v;
        repeat (3) @(posedge core_clk_i);
    endtask

    // measures the generated clock between its level changes
    always @(posedge core_clk_i) begin
        if (pin_wire_i != last_q) begin
            half_per_o <= run_q;
            run_q <= 1;
        end else begin
            run_q <= run_q + 1;
        end
        last_q <= pin_wire_i;
    end
endmodule // tm2_pin_model

// ### timer2_reload_clockout_tb.sv
`timescale 1ns/1ps
`include "tm2_cfg.svh"
`define TB_CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_fail++; $display("[FAIL] t=%0t got=%0h exp=%0h", $time, a, e); end end
module timer2_reload_clockout_tb;
    import tm2_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [2:0]  addr = 3'h0;
    tm2_byte_t   wdat = 8'h00;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        rd_d1 = 1'b0;
    tm2_byte_t   rdat;
    logic        pin_o, pin_oe, irq, btick, m_drv, m_oe, dir, pin_w;
    int unsigned half_per;
    int          n_fail = 0;
    int          total_checks = 0;
    int          cyc = 0;
    int          nb;
    tm2_byte_t   rnd;
    tm2_byte_t   exp_b;
    tm2_byte_t   exp_q[$];
    tm2_byte_t   c_ctl[3] = '{8'h08, 8'h09, 8'h28};
    tm2_byte_t   e_cnt[3] = '{8'h33, 8'h55, 8'h55};
    tm2_byte_t   e_rld[3] = '{8'h33, 8'h55, 8'h33};
    tm2_byte_t   e_ctl[3] = '{8'h48, 8'h49, 8'h28};
    tm2_byte_t   e_sts[3] = '{8'h02, 8'h02, 8'h00};

    always #20 clk = ~clk;
    // a count pin nobody drives floats high through its pull-up
    assign pin_w = pin_oe ? pin_o : (m_oe ? m_drv : 1'b1);

    tm2_top #(.PRESC_DIV(4)) dut_u (.core_clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr), .reg_wdata_i(wdat),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat), .count_pin_i(pin_w), .count_pin_o(pin_o),
        .count_pin_oe_o(pin_oe), .dir_pin_i(dir), .irq_o(irq), .baud_tick_o(btick));
    tm2_pin_model pm_u (.core_clk_i(clk), .pin_wire_i(pin_w), .cnt_drv_o(m_drv), .cnt_oe_o(m_oe),
        .dir_o(dir), .half_per_o(half_per));

    // read data stand only in the cycle after the strobe
    always @(posedge clk) begin
        if (rd_d1) begin
            // pop once: the compare macro evaluates its expected argument twice on a mismatch
            exp_b = exp_q.pop_front();
            `TB_CHK(rdat, exp_b)
        end
        rd_d1 <= rd;
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            wrap_up();
        end
    end

    task automatic wr_reg(input logic [2:0] a, input tm2_byte_t d);
        @(posedge clk);
        addr <= a;
        wdat <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [2:0] a, input tm2_byte_t e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk);
        rd <= 1'b0;
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        void'($urandom(91));
        rnd = 8'($urandom());
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        for (int a = 0; a < 8; a++) rd_chk(3'(a), 8'h00);
        wr_reg(`TM2_OFS_MODE, 8'hFF);
        rd_chk(`TM2_OFS_MODE, 8'h03);
        #1 `TB_CHK(pin_oe, 1'b1)
        wr_reg(`TM2_OFS_MODE, 8'h00);
        $display("test reset done");
        wr_reg(`TM2_OFS_IRQ_MSK, 8'h03);
        wr_reg(`TM2_OFS_RLD_LO, rnd);
        wr_reg(`TM2_OFS_RLD_HI, 8'h12);
        wr_reg(`TM2_OFS_CNT_LO, 8'hFF);
        wr_reg(`TM2_OFS_CNT_HI, 8'h00);
        wr_reg(`TM2_OFS_CTRL, 8'h06);
        pm_u.pulse(1);
        rd_chk(`TM2_OFS_CNT_HI, 8'h01);
        rd_chk(`TM2_OFS_CNT_LO, 8'h00);
        wr_reg(`TM2_OFS_CNT_HI, 8'hFF);
        wr_reg(`TM2_OFS_CNT_LO, 8'hFF);
        pm_u.pulse(1);
        rd_chk(`TM2_OFS_CNT_LO, rnd);
        rd_chk(`TM2_OFS_CNT_HI, 8'h12);
        rd_chk(`TM2_OFS_CTRL, 8'h86);
        #1 `TB_CHK(irq, 1'b1)
        rd_chk(`TM2_OFS_IRQ_STS, 8'h01);
        #1 `TB_CHK(irq, 1'b0)
        rd_chk(`TM2_OFS_IRQ_STS, 8'h00);
        rd_chk(`TM2_OFS_CTRL, 8'h86);
        wr_reg(`TM2_OFS_CTRL, 8'h02);
        pm_u.pulse(2);
        rd_chk(`TM2_OFS_CNT_LO, rnd);
        $display("test counter done");
        // run window of 40 clocks is a whole number of prescaler periods
        wr_reg(`TM2_OFS_CNT_LO, 8'h00);
        wr_reg(`TM2_OFS_CNT_HI, 8'h00);
        wr_reg(`TM2_OFS_CTRL, 8'h04);
        repeat (38) @(posedge clk);
        wr_reg(`TM2_OFS_CTRL, 8'h00);
        rd_chk(`TM2_OFS_CNT_LO, 8'h0A);
        $display("test timer done");
        wr_reg(`TM2_OFS_MODE, 8'h01);
        wr_reg(`TM2_OFS_RLD_LO, 8'h10);
        wr_reg(`TM2_OFS_RLD_HI, 8'h00);
        wr_reg(`TM2_OFS_CNT_LO, 8'h11);
        wr_reg(`TM2_OFS_CNT_HI, 8'h00);
        pm_u.set_dir(1'b0);
        wr_reg(`TM2_OFS_CTRL, 8'h06);
        pm_u.pulse(2);
        rd_chk(`TM2_OFS_CNT_LO, 8'hFF);
        rd_chk(`TM2_OFS_CNT_HI, 8'hFF);
        rd_chk(`TM2_OFS_CTRL, 8'hC6);
        rd_chk(`TM2_OFS_IRQ_STS, 8'h01);
        pm_u.set_dir(1'b1);
        pm_u.pulse(1);
        rd_chk(`TM2_OFS_CNT_LO, 8'h10);
        rd_chk(`TM2_OFS_CTRL, 8'h86);
        rd_chk(`TM2_OFS_IRQ_STS, 8'h01);
        $display("test updown done");
        wr_reg(`TM2_OFS_MODE, 8'h00);
        for (int i = 0; i < 3; i++) begin
            wr_reg(`TM2_OFS_RLD_LO, 8'h33);
            wr_reg(`TM2_OFS_CNT_LO, 8'h55);
            wr_reg(`TM2_OFS_CTRL, c_ctl[i]);
            pm_u.set_dir(1'b0);
            pm_u.set_dir(1'b1);
            rd_chk(`TM2_OFS_CNT_LO, e_cnt[i]);
            rd_chk(`TM2_OFS_RLD_LO, e_rld[i]);
            rd_chk(`TM2_OFS_CTRL, e_ctl[i]);
            rd_chk(`TM2_OFS_IRQ_STS, e_sts[i]);
        end
        $display("test external done");
        wr_reg(`TM2_OFS_MODE, 8'h02);
        wr_reg(`TM2_OFS_CTRL, 8'h10);
        wr_reg(`TM2_OFS_RLD_LO, 8'hFC);
        wr_reg(`TM2_OFS_RLD_HI, 8'hFF);
        wr_reg(`TM2_OFS_CNT_LO, 8'hFC);
        wr_reg(`TM2_OFS_CNT_HI, 8'hFF);
        wr_reg(`TM2_OFS_CTRL, 8'h14);
        repeat (40) @(posedge clk);
        #1 `TB_CHK(pin_oe, 1'b1)
        `TB_CHK(half_per, 32'd8)
        nb = 0;
        repeat (64) begin
            @(posedge clk);
            if (btick === 1'b1) nb++;
        end
        `TB_CHK(nb, 8)
        rd_chk(`TM2_OFS_CTRL, 8'h14);
        rd_chk(`TM2_OFS_IRQ_STS, 8'h00);
        #1 `TB_CHK(irq, 1'b0)
        // clock-out alone: serial select cleared, output enable alone must keep the flag quiet
        wr_reg(`TM2_OFS_CTRL, 8'h04);
        repeat (40) @(posedge clk);
        `TB_CHK(half_per, 32'd8)
        `TB_CHK(btick, 1'b0)
        rd_chk(`TM2_OFS_CTRL, 8'h04);
        rd_chk(`TM2_OFS_IRQ_STS, 8'h00);
        $display("test clockout done");
        // reset in mid-run while the clock output is toggling
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        #1 `TB_CHK(pin_oe, 1'b0)
        rd_chk(`TM2_OFS_CTRL, 8'h00);
        rd_chk(`TM2_OFS_CNT_HI, 8'h00);
        rd_chk(`TM2_OFS_MODE, 8'h00);
        $display("test midrun reset done");
        repeat (2) @(posedge clk);
        wrap_up();
    end
endmodule // timer2_reload_clockout_tb
